/* machine_trap_cause_logic_tb.sv */
// Self-checking bench for the machine trap cause block.
// Assumes the pipeline model drives the trap port and tasks drive the register port.
`timescale 1ns/100ps
module machine_trap_cause_logic_tb;
    import mtc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [MTC_AW-1:0] reg_addr_in = '0;
    logic [MTC_MRW-1:0] reg_wr_data_in = '0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [MTC_MRW-1:0] reg_rd_data_out, trap_cause_out, trap_epc_out, trap_value_out, pc;
    logic trap_entry_out, trap_take;
    logic go = 1'b0;
    logic [27:0] cmd = '0;
    logic [27:0] fld;
    logic [MTC_MRW-1:0] pc_cmd = 64'h8000_1001;
    logic [MTC_MRW-1:0] exp_cause = '0;
    int n_errors = 0;
    int checked = 0;

    initial
    begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    mtc_pipe_model mtc_pipe_model_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .go_in(go), .cmd_in(cmd), .pc_cmd_in(pc_cmd), .trap_take_out(trap_take),
        .fld_out(fld), .pc_out(pc));

    mtc_trap_cause mtc_trap_cause_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wr_data_in(reg_wr_data_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rd_data_out(reg_rd_data_out), .trap_take_in(trap_take),
        .trap_is_irq_in(fld[27]), .irq_pend_in(fld[26:20]), .exc_req_in(fld[19:6]),
        .priv_viol_in(fld[5]), .itrans_page_in(fld[4]), .mtrans_page_in(fld[3]),
        .mem_is_store_in(fld[2]), .priv_mode_in(fld[1:0]), .pc_in(pc),
        .fetch_addr_in(pc ^ 64'h100), .data_addr_in(pc ^ 64'h200),
        .insn_bits_in(pc[31:0] ^ 32'h13), .swchk_info_in(pc ^ 64'h300),
        .trap_cause_out(trap_cause_out), .trap_epc_out(trap_epc_out),
        .trap_value_out(trap_value_out), .trap_entry_out(trap_entry_out));

    task automatic final_report();
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wr_data_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [63:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rd_data_out, e);
    endtask

    function automatic logic [27:0] xc(input logic [13:0] r, input logic [5:0] f);
        return {8'h0, r, f};
    endfunction

    task automatic trap(input logic [27:0] c, input logic col, input logic [5:0] code,
                        input mtc_tval_sel_t ts);
        logic ok;
        logic [63:0] tv;
        ok = c[27] ? |c[26:20] : |c[19:5];
        @(posedge ref_clk_in);
        go <= 1'b1;
        cmd <= c;
        pc_cmd <= pc_cmd + 64'h1235;
        @(posedge ref_clk_in);
        go <= 1'b0;
        reg_wr_in <= col;
        reg_addr_in <= MTC_OFF_CAUSE;
        reg_wr_data_in <= 64'h5;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        #1;
        case (ts)
            MTC_TV_PC: tv = pc_cmd;
            MTC_TV_FADDR: tv = pc_cmd ^ 64'h100;
            MTC_TV_DADDR: tv = pc_cmd ^ 64'h200;
            MTC_TV_INSN: tv = {32'h0, pc_cmd[31:0] ^ 32'h13};
            MTC_TV_SWCHK: tv = pc_cmd ^ 64'h300;
            default: tv = '0;
        endcase
        if (ok)
            exp_cause = {c[27], 57'h0, code};
        chk(64'(trap_entry_out), 64'(ok));
        chk(trap_cause_out, exp_cause);
        if (ok)
        begin
            chk(trap_epc_out, pc_cmd & ~64'h1);
            chk(trap_value_out, tv);
        end
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        rdc(MTC_OFF_CAUSE, MTC_CAUSE_RST);
        rdc(8'h28, 64'h0);
        wr(MTC_OFF_CAUSE, 64'h8000_0000_0000_000b);
        rdc(MTC_OFF_CAUSE, 64'h8000_0000_0000_000b);
        wr(MTC_OFF_CAUSE, 64'h0a);
        rdc(MTC_OFF_CAUSE, 64'h0);
        wr(MTC_OFF_EPC, 64'h1235);
        rdc(MTC_OFF_EPC, 64'h1234);
        for (int i = 0; i < MTC_IRQN; i++)
            trap({1'b1, 7'(1 << i), 20'h0}, 1'b0, 6'(2 * i + 1), MTC_TV_ZERO);
        trap({1'b1, 7'h7f, 20'h0}, 1'b0, MTC_I_MEI, MTC_TV_ZERO);
        trap(28'h0, 1'b0, 6'h0, MTC_TV_ZERO);
        rdc(MTC_OFF_STAT, 64'h3);
        trap(xc(14'h0011, 6'h00), 1'b0, MTC_E_BRK, MTC_TV_PC);
        trap(xc(14'h0006, 6'h10), 1'b0, MTC_E_IPAGE, MTC_TV_FADDR);
        trap(xc(14'h0002, 6'h00), 1'b0, MTC_E_IACC, MTC_TV_FADDR);
        trap(xc(14'h0014, 6'h00), 1'b0, MTC_E_IACC, MTC_TV_FADDR);
        trap(xc(14'h0018, 6'h00), 1'b0, MTC_E_HWERR, MTC_TV_FADDR);
        trap(xc(14'h0000, 6'h20), 1'b1, MTC_E_ILLEGAL, MTC_TV_INSN);
        trap(xc(14'h0030, 6'h00), 1'b0, MTC_E_ILLEGAL, MTC_TV_INSN);
        trap(xc(14'h0060, 6'h00), 1'b0, MTC_E_IMISAL, MTC_TV_FADDR);
        trap(xc(14'h0040, 6'h00), 1'b0, MTC_E_ECALL, MTC_TV_ZERO);
        trap(xc(14'h0040, 6'h01), 1'b0, 6'h09, MTC_TV_ZERO);
        trap(xc(14'h0040, 6'h03), 1'b0, 6'h0b, MTC_TV_ZERO);
        trap(xc(14'h0080, 6'h00), 1'b0, MTC_E_BRK, MTC_TV_PC);
        trap(xc(14'h0300, 6'h00), 1'b0, MTC_E_BRK, MTC_TV_DADDR);
        trap(xc(14'h0600, 6'h00), 1'b0, MTC_E_SWCHK, MTC_TV_SWCHK);
        trap(xc(14'h1800, 6'h08), 1'b0, MTC_E_LPAGE, MTC_TV_DADDR);
        trap(xc(14'h1800, 6'h0c), 1'b0, MTC_E_SPAGE, MTC_TV_DADDR);
        trap(xc(14'h1000, 6'h00), 1'b0, MTC_E_LACC, MTC_TV_DADDR);
        trap(xc(14'h1000, 6'h04), 1'b0, MTC_E_SACC, MTC_TV_DADDR);
        trap(xc(14'h0c00, 6'h00), 1'b0, MTC_E_LACC, MTC_TV_DADDR);
        trap(xc(14'h0400, 6'h04), 1'b0, MTC_E_SMISAL, MTC_TV_DADDR);
        trap(xc(14'h2400, 6'h00), 1'b0, MTC_E_HWERR, MTC_TV_DADDR);
        wr(MTC_OFF_CTRL, 64'h1);
        rdc(MTC_OFF_CTRL, 64'h1);
        trap(xc(14'h0c00, 6'h08), 1'b0, MTC_E_LMISAL, MTC_TV_DADDR);
        repeat (20) @(posedge ref_clk_in);
        #1 chk(trap_cause_out, exp_cause);
        rdc(MTC_OFF_STAT, 64'h1);
        final_report();
    end

    initial
    begin
        #(2000 * 100);
        n_errors++;
        final_report();
    end
endmodule // machine_trap_cause_logic_tb

/* mtc_exc_if.sv */
// Carries exception requests to the priority picker and its choice back.
// Assumes both ends share the hart clock; the picker is combinational.
`timescale 1ns/100ps
interface mtc_exc_if;
    import mtc_pkg::*;
    logic [MTC_XN-1:0] req;
    logic itrans_page;
    logic mtrans_page;
    logic is_store;
    logic misal_hi;
    logic [1:0] priv;
    logic valid;
    logic [MTC_CW-1:0] code;
    mtc_tval_sel_t tsel;
    modport src (output req, itrans_page, mtrans_page, is_store, misal_hi, priv,
                 input valid, code, tsel);
    modport pick (input req, itrans_page, mtrans_page, is_store, misal_hi, priv,
                  output valid, code, tsel);
endinterface

/* mtc_exc_prio.sv */
// Picks the single highest-priority synchronous exception of an instruction.
// Assumes request bits are valid only in the cycle of trap entry.
`timescale 1ns/100ps
module mtc_exc_prio
    import mtc_pkg::*;
(
    mtc_exc_if.pick x
);

    function automatic logic [MTC_CW-1:0] ls_code(input logic st, input logic [MTC_CW-1:0] ld,
                                                 input logic [MTC_CW-1:0] sc);
        ls_code = st ? sc : ld;
    endfunction

    // ------------------------------------------------------------
    // Fixed priority chain
    // ------------------------------------------------------------
    always_comb
    begin
        x.valid = |x.req;
        x.code = MTC_E_IMISAL;
        x.tsel = MTC_TV_ZERO;
        if (x.req[MTC_X_IBRK])
        begin
            x.code = MTC_E_BRK;
            x.tsel = MTC_TV_PC;
        end
        else if (x.req[MTC_X_ITRANS])
        begin
            x.code = x.itrans_page ? MTC_E_IPAGE : MTC_E_IACC;
            x.tsel = MTC_TV_FADDR;
        end
        else if (x.req[MTC_X_IACC])
        begin
            x.code = MTC_E_IACC;
            x.tsel = MTC_TV_FADDR;
        end
        else if (x.req[MTC_X_HWF])
        begin
            x.code = MTC_E_HWERR;
            x.tsel = MTC_TV_FADDR;
        end
        else if (x.req[MTC_X_ILLEGAL])
        begin
            x.code = MTC_E_ILLEGAL;
            x.tsel = MTC_TV_INSN;
        end
        else if (x.req[MTC_X_IMISAL])
        begin
            x.code = MTC_E_IMISAL;
            x.tsel = MTC_TV_FADDR;
        end
        else if (x.req[MTC_X_ECALL])
        begin
            x.code = MTC_E_ECALL | {4'h0, x.priv};
        end
        else if (x.req[MTC_X_EBRK])
        begin
            x.code = MTC_E_BRK;
            x.tsel = MTC_TV_PC;
        end
        else if (x.req[MTC_X_DBRK])
        begin
            x.code = MTC_E_BRK;
            x.tsel = MTC_TV_DADDR;
        end
        else if (x.req[MTC_X_SWCHK])
        begin
            x.code = MTC_E_SWCHK;
            x.tsel = MTC_TV_SWCHK;
        end
        else if (x.req[MTC_X_LSMISAL] && x.misal_hi)
        begin
            x.code = ls_code(x.is_store, MTC_E_LMISAL, MTC_E_SMISAL);
            x.tsel = MTC_TV_DADDR;
        end
        else if (x.req[MTC_X_MTRANS])
        begin
            x.code = x.mtrans_page ? ls_code(x.is_store, MTC_E_LPAGE, MTC_E_SPAGE)
                                   : ls_code(x.is_store, MTC_E_LACC, MTC_E_SACC);
            x.tsel = MTC_TV_DADDR;
        end
        else if (x.req[MTC_X_MACC])
        begin
            x.code = ls_code(x.is_store, MTC_E_LACC, MTC_E_SACC);
            x.tsel = MTC_TV_DADDR;
        end
        else if (x.req[MTC_X_HWM])
        begin
            x.code = MTC_E_HWERR;
            x.tsel = MTC_TV_DADDR;
        end
        else if (x.req[MTC_X_LSMISAL])
        begin
            x.code = ls_code(x.is_store, MTC_E_LMISAL, MTC_E_SMISAL);
            x.tsel = MTC_TV_DADDR;
        end
    end

endmodule // mtc_exc_prio

/* mtc_pipe_model.sv */
// Pipeline model that offers one trap request to the block per go pulse.
// Assumes the hart clock; request fields are scrambled while no trap is offered.
`timescale 1ns/100ps
module mtc_pipe_model
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Command from the bench
    input wire logic go_in,
    input wire logic [MTC_IRQN+MTC_XN+6:0] cmd_in,
    input wire logic [MTC_MRW-1:0] pc_cmd_in,
    // Trap request to the block
    output logic trap_take_out,
    output logic [MTC_IRQN+MTC_XN+6:0] fld_out,
    output logic [MTC_MRW-1:0] pc_out
);
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            trap_take_out <= 1'b0;
            fld_out <= '0;
            pc_out <= '0;
        end
        else if (go_in)
        begin
            trap_take_out <= 1'b1;
            fld_out <= cmd_in;
            pc_out <= pc_cmd_in;
        end
        else
        begin
            trap_take_out <= 1'b0;
            fld_out <= ~fld_out;
            pc_out <= ~pc_out;
        end
    end
endmodule // mtc_pipe_model

/* mtc_pkg.sv */
// Constants shared by the trap cause block and its exception priority picker.
// Assumes a single hart clock and a pipeline on the same clock.
package mtc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int MTC_MRW = 64;
    localparam int MTC_CW = 6;
    localparam int MTC_IRQN = 7;
    localparam int MTC_XN = 14;
    localparam int MTC_AW = 8;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] MTC_OFF_CAUSE = 8'h00;
    localparam logic [7:0] MTC_OFF_EPC = 8'h08;
    localparam logic [7:0] MTC_OFF_TVAL = 8'h10;
    localparam logic [7:0] MTC_OFF_CTRL = 8'h18;
    localparam logic [7:0] MTC_OFF_STAT = 8'h20;
    localparam int MTC_IRQ_BIT = 63;
    localparam int MTC_CTRL_MISAL_HI = 0;
    localparam logic [63:0] MTC_CAUSE_RST = 64'h0;
    localparam logic [63:0] MTC_EPC_RST = 64'h0;
    localparam logic [63:0] MTC_TVAL_RST = 64'h0;
    localparam logic MTC_MISAL_HI_RST = 1'b0;

    // ------------------------------------------------------------
    // Interrupt cause codes
    // ------------------------------------------------------------
    localparam logic [5:0] MTC_I_SSI = 6'h01;
    localparam logic [5:0] MTC_I_MSI = 6'h03;
    localparam logic [5:0] MTC_I_STI = 6'h05;
    localparam logic [5:0] MTC_I_MTI = 6'h07;
    localparam logic [5:0] MTC_I_SEI = 6'h09;
    localparam logic [5:0] MTC_I_MEI = 6'h0b;
    localparam logic [5:0] MTC_I_LCOF = 6'h0d;

    // ------------------------------------------------------------
    // Exception cause codes
    // ------------------------------------------------------------
    localparam logic [5:0] MTC_E_IMISAL = 6'h00;
    localparam logic [5:0] MTC_E_IACC = 6'h01;
    localparam logic [5:0] MTC_E_ILLEGAL = 6'h02;
    localparam logic [5:0] MTC_E_BRK = 6'h03;
    localparam logic [5:0] MTC_E_LMISAL = 6'h04;
    localparam logic [5:0] MTC_E_LACC = 6'h05;
    localparam logic [5:0] MTC_E_SMISAL = 6'h06;
    localparam logic [5:0] MTC_E_SACC = 6'h07;
    localparam logic [5:0] MTC_E_ECALL = 6'h08;
    localparam logic [5:0] MTC_E_IPAGE = 6'h0c;
    localparam logic [5:0] MTC_E_LPAGE = 6'h0d;
    localparam logic [5:0] MTC_E_SPAGE = 6'h0f;
    localparam logic [5:0] MTC_E_SWCHK = 6'h12;
    localparam logic [5:0] MTC_E_HWERR = 6'h13;

    // ------------------------------------------------------------
    // Exception request positions
    // ------------------------------------------------------------
    localparam int MTC_X_IBRK = 0;
    localparam int MTC_X_ITRANS = 1;
    localparam int MTC_X_IACC = 2;
    localparam int MTC_X_HWF = 3;
    localparam int MTC_X_ILLEGAL = 4;
    localparam int MTC_X_IMISAL = 5;
    localparam int MTC_X_ECALL = 6;
    localparam int MTC_X_EBRK = 7;
    localparam int MTC_X_DBRK = 8;
    localparam int MTC_X_SWCHK = 9;
    localparam int MTC_X_LSMISAL = 10;
    localparam int MTC_X_MTRANS = 11;
    localparam int MTC_X_MACC = 12;
    localparam int MTC_X_HWM = 13;

    // Source of the trap value on exception entry.
    typedef enum logic [2:0] {
        MTC_TV_ZERO = 3'b000,
        MTC_TV_PC = 3'b001,
        MTC_TV_FADDR = 3'b010,
        MTC_TV_DADDR = 3'b011,
        MTC_TV_INSN = 3'b100,
        MTC_TV_SWCHK = 3'b101
    } mtc_tval_sel_t;

endpackage

/* mtc_trap_cause.sv */
// Machine trap cause, return address and trap value registers of one hart.
// Assumes a pipeline on the same clock that pulses trap_take_in on trap entry.
`timescale 1ns/100ps

// Contract
// - Trap entry loads cause with event code.
// - Otherwise only software writes change cause.
// - Interrupt flag set for interrupts only.
// - Interrupt flag is most significant bit.
// - Cause field keeps supported codes only; code also keeps interrupt codes 16-63.
// - Interrupt codes 1,3,5,7,9,11,13.
// - Exception codes 0-9,11-13,15,18,19 as listed; ecall with priv_mode_in 2 still loads code 10 on entry.
// - Loads report load class, stores store class.
// - Privilege violations report illegal instruction.
// - Several exceptions: record highest priority one.
// - Instruction breakpoint highest, shares code 3.
// - Fetch translation faults, then fetch access.
// - Illegal, misaligned target, ecall, breaks tier.
// - Misaligned target ranks below fetch faults.
// - Data translation faults outrank physical faults.
// - Data misaligned ranked high or lowest.
// - Software check sets trap value.
// - Hardware error: return address, fault address.
// - Hardware error ranked where discovered.
// - Trap entry loads return address with pc.
module mtc_trap_cause
    import mtc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [MTC_AW-1:0] reg_addr_in,
    input wire logic [MTC_MRW-1:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [MTC_MRW-1:0] reg_rd_data_out,
    // Pipeline trap requests
    input wire logic trap_take_in,
    input wire logic trap_is_irq_in,
    input wire logic [MTC_IRQN-1:0] irq_pend_in,
    input wire logic [MTC_XN-1:0] exc_req_in,
    input wire logic priv_viol_in,
    input wire logic itrans_page_in,
    input wire logic mtrans_page_in,
    input wire logic mem_is_store_in,
    input wire logic [1:0] priv_mode_in,
    // Trap information
    input wire logic [MTC_MRW-1:0] pc_in,
    input wire logic [MTC_MRW-1:0] fetch_addr_in,
    input wire logic [MTC_MRW-1:0] data_addr_in,
    input wire logic [31:0] insn_bits_in,
    input wire logic [MTC_MRW-1:0] swchk_info_in,
    // Register views
    output logic [MTC_MRW-1:0] trap_cause_out,
    output logic [MTC_MRW-1:0] trap_epc_out,
    output logic [MTC_MRW-1:0] trap_value_out,
    output logic trap_entry_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [MTC_MRW-1:0] cause_q;
    logic [MTC_MRW-1:0] epc_q;
    logic [MTC_MRW-1:0] tval_q;
    logic [MTC_MRW-1:0] rd_data_q;
    logic misal_hi_q;
    logic seen_q;
    logic last_irq_q;
    logic entry_q;
    logic entry;
    logic irq_entry;
    logic [MTC_CW-1:0] irq_cd;
    logic [MTC_CW-1:0] new_code;
    logic [MTC_MRW-1:0] new_tval;
    logic cause_wr;
    logic epc_wr;
    logic tval_wr;
    logic ctrl_wr;

    mtc_exc_if exc ();

    // Interrupt choice when several are pending; machine before supervisor.
    function automatic logic [MTC_CW-1:0] irq_code(input logic [MTC_IRQN-1:0] p);
        if (p[5])
            irq_code = MTC_I_MEI;
        else if (p[1])
            irq_code = MTC_I_MSI;
        else if (p[3])
            irq_code = MTC_I_MTI;
        else if (p[4])
            irq_code = MTC_I_SEI;
        else if (p[0])
            irq_code = MTC_I_SSI;
        else if (p[2])
            irq_code = MTC_I_STI;
        else
            irq_code = MTC_I_LCOF;
    endfunction

    // Cause field holds supported codes and interrupt codes 16 and up; others read back as zero.
    function automatic logic [MTC_CW-1:0] legal_code(input logic irq, input logic [MTC_CW-1:0] c);
        if (irq)
            legal_code = (c[0] && c <= MTC_I_LCOF) || c >= 6'h10 ? c : 6'h00;
        else
            legal_code = (c <= MTC_E_SACC) || c == MTC_E_ECALL || c == 6'h09 || c == 6'h0b
                         || c == MTC_E_IPAGE || c == MTC_E_LPAGE || c == MTC_E_SPAGE
                         || c == MTC_E_SWCHK || c == MTC_E_HWERR ? c : 6'h00;
    endfunction

    // ------------------------------------------------------------
    // Exception priority
    // ------------------------------------------------------------
    always_comb
    begin
        exc.req = exc_req_in;
        exc.req[MTC_X_ILLEGAL] = exc_req_in[MTC_X_ILLEGAL] | priv_viol_in;
        exc.itrans_page = itrans_page_in;
        exc.mtrans_page = mtrans_page_in;
        exc.is_store = mem_is_store_in;
        exc.misal_hi = misal_hi_q;
        exc.priv = priv_mode_in;
    end

    mtc_exc_prio mtc_exc_prio_inst (
        .x(exc.pick)
    );

    // ------------------------------------------------------------
    // Trap entry decode
    // ------------------------------------------------------------
    assign irq_cd = irq_code(irq_pend_in);
    assign irq_entry = trap_take_in && trap_is_irq_in && (|irq_pend_in);
    assign entry = irq_entry || (trap_take_in && !trap_is_irq_in && exc.valid);
    assign new_code = irq_entry ? irq_cd : exc.code;
    assign cause_wr = reg_wr_in && reg_addr_in == MTC_OFF_CAUSE;
    assign epc_wr = reg_wr_in && reg_addr_in == MTC_OFF_EPC;
    assign tval_wr = reg_wr_in && reg_addr_in == MTC_OFF_TVAL;
    assign ctrl_wr = reg_wr_in && reg_addr_in == MTC_OFF_CTRL;

    always_comb
    begin
        new_tval = '0;
        if (!irq_entry)
        begin
            unique case (exc.tsel)
                MTC_TV_ZERO: new_tval = '0;
                MTC_TV_PC: new_tval = pc_in;
                MTC_TV_FADDR: new_tval = fetch_addr_in;
                MTC_TV_DADDR: new_tval = data_addr_in;
                MTC_TV_INSN: new_tval = {32'h0, insn_bits_in};
                MTC_TV_SWCHK: new_tval = swchk_info_in;
                default: new_tval = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Trap cause register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            cause_q <= MTC_CAUSE_RST;
        else if (entry)
            cause_q <= {irq_entry, 57'h0, new_code};
        else if (cause_wr)
            cause_q <= {reg_wr_data_in[MTC_IRQ_BIT], 57'h0,
                        legal_code(reg_wr_data_in[MTC_IRQ_BIT],
                                   reg_wr_data_in[MTC_CW-1:0])};
    end

    // ------------------------------------------------------------
    // Return address and trap value
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            epc_q <= MTC_EPC_RST;
        else if (entry)
            epc_q <= {pc_in[MTC_MRW-1:1], 1'b0};
        else if (epc_wr)
            epc_q <= {reg_wr_data_in[MTC_MRW-1:1], 1'b0};
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            tval_q <= MTC_TVAL_RST;
        else if (entry)
            tval_q <= new_tval;
        else if (tval_wr)
            tval_q <= reg_wr_data_in;
    end

    // ------------------------------------------------------------
    // Control and status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            misal_hi_q <= MTC_MISAL_HI_RST;
        else if (ctrl_wr)
            misal_hi_q <= reg_wr_data_in[MTC_CTRL_MISAL_HI];
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            seen_q <= 1'b0;
            last_irq_q <= 1'b0;
            entry_q <= 1'b0;
        end
        else
        begin
            entry_q <= entry;
            if (entry)
            begin
                seen_q <= 1'b1;
                last_irq_q <= irq_entry;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rd_data_q <= '0;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                MTC_OFF_CAUSE: rd_data_q <= cause_q;
                MTC_OFF_EPC: rd_data_q <= epc_q;
                MTC_OFF_TVAL: rd_data_q <= tval_q;
                MTC_OFF_CTRL: rd_data_q <= {63'h0, misal_hi_q};
                MTC_OFF_STAT: rd_data_q <= {62'h0, last_irq_q, seen_q};
                default: rd_data_q <= '0;
            endcase
        end
        else
            rd_data_q <= '0;
    end

    assign reg_rd_data_out = rd_data_q;
    assign trap_cause_out = cause_q;
    assign trap_epc_out = epc_q;
    assign trap_value_out = tval_q;
    assign trap_entry_out = entry_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    cause_load_a: assert property (
        entry
        |=> cause_q[MTC_CW-1:0] == $past(new_code) && trap_entry_out)
        else $error("cause not loaded on trap entry");

    cause_hold_a: assert property (
        !entry && !cause_wr
        |=> $stable(cause_q))
        else $error("cause changed outside trap entry");

    irq_flag_a: assert property (
        entry
        |=> cause_q[MTC_IRQ_BIT] == $past(trap_is_irq_in) && cause_q[62:MTC_CW] == '0)
        else $error("interrupt flag wrong after entry");

    sign_bit_a: assert property (
        entry && trap_is_irq_in
        |=> $signed(cause_q) < 0)
        else $error("interrupt cause not negative");

    mei_code_a: assert property (
        irq_entry && irq_pend_in[5]
        |=> cause_q[5:0] == 6'h0b)
        else $error("machine external code wrong");

    ecall_code_a: assert property (
        entry && !trap_is_irq_in && exc_req_in == 14'h0040 && !priv_viol_in
        && priv_mode_in == 2'h1 |=> cause_q[5:0] == 6'h09)
        else $error("supervisor ecall code wrong");

    priv_viol_a: assert property (
        entry && !trap_is_irq_in && priv_viol_in && exc_req_in[3:0] == 4'h0
        |=> cause_q[5:0] == 6'h02)
        else $error("privilege violation not illegal");

    ibrk_top_a: assert property (
        entry && !trap_is_irq_in && exc_req_in[MTC_X_IBRK]
        |=> cause_q[5:0] == 6'h03 && tval_q == $past(pc_in))
        else $error("instruction breakpoint not first");

    fetch_order_a: assert property (
        entry && !trap_is_irq_in && exc_req_in[2:0] == 3'h6 && itrans_page_in
        |=> cause_q[5:0] == 6'h0c)
        else $error("fetch translation fault not first");

    store_class_a: assert property (
        entry && !trap_is_irq_in && exc_req_in == 14'h1000 && !priv_viol_in && mem_is_store_in
        |=> cause_q[5:0] == 6'h07)
        else $error("store access code wrong");

    misal_low_a: assert property (
        entry && !trap_is_irq_in && !misal_hi_q && exc_req_in == 14'h0c00 && !priv_viol_in
        |=> cause_q[5:0] inside {6'h05, 6'h07, 6'h0d, 6'h0f})
        else $error("misaligned not lowest");

    epc_load_a: assert property (
        entry
        |=> epc_q == {$past(pc_in[63:1]), 1'b0})
        else $error("return address not loaded");

    imisal_rank_a: assert property (
        entry && !trap_is_irq_in && exc_req_in[5:0] == 6'h20 && !priv_viol_in
        |=> cause_q[5:0] == 6'h00 && tval_q == $past(fetch_addr_in))
        else $error("misaligned target misranked");

    swchk_val_a: assert property (
        entry && !trap_is_irq_in && exc_req_in[9:0] == 10'h200 && !priv_viol_in
        |=> cause_q[5:0] == 6'h12 && tval_q == $past(swchk_info_in))
        else $error("software check value wrong");

    hwerr_val_a: assert property (
        entry && !trap_is_irq_in && exc_req_in == 14'h2400 && !misal_hi_q && !priv_viol_in
        |=> epc_q == {$past(pc_in[63:1]), 1'b0} && tval_q == $past(data_addr_in))
        else $error("hardware error values wrong");

    hwf_rank_a: assert property (
        entry && !trap_is_irq_in && exc_req_in[3:0] == 4'h8
        |=> cause_q[5:0] == 6'h13 && tval_q == $past(fetch_addr_in))
        else $error("fetch hardware error misranked");

    irq_entry_c: cover property (irq_entry ##1 trap_entry_out);
    exc_entry_c: cover property (entry && !trap_is_irq_in && $countones(exc_req_in) > 1);
    sw_write_c: cover property (cause_wr ##1 reg_rd_in && reg_addr_in == MTC_OFF_CAUSE);
    misal_hi_c: cover property (entry && misal_hi_q && exc_req_in[MTC_X_LSMISAL]);
    trap_win_c: cover property (entry && cause_wr);

endmodule // mtc_trap_cause
